// ---- dv/gcs_host_model.sv ----
`timescale 1ns/1ps
module gcs_host_model (
  // clock
  input  logic       clk_sys_in,
  // answer
  input  logic [7:0] reg_rdata_out,
  input  logic       reg_rvalid_out,
  // request
  output logic [7:0] reg_addr_in,
  output logic       reg_wr_in,
  output logic       reg_rd_in,
  output logic [7:0] reg_wdata_in
);
  // set only where a scenario writes reserved bits on purpose
  logic raw = 1'b0;
  initial begin
    reg_addr_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_wdata_in = 8'h00;
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wr_in <= wr;
    reg_rd_in <= !wr;
    reg_wdata_in <= (!raw && (a == 8'haa || a == 8'hab)) ? (d & 8'h03) : d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    reg_addr_in <= ~a;
    reg_wdata_in <= ~d;
    q = 8'h00;
    // the answer flops at the edge that took the read; look once it has settled
    if (!wr) begin
      #1;
      q = reg_rvalid_out ? reg_rdata_out : 8'hxx;
    end
  endtask
endmodule // gcs_host_model

// ---- dv/gcs_regs_checker.sv ----
`timescale 1ns/1ps
module gcs_regs_checker (
  // clock and reset
  input logic       clk_sys_in,
  input logic       rst_in,
  // register port
  input logic [7:0] reg_addr_in,
  input logic       reg_wr_in,
  input logic       reg_rd_in,
  input logic [7:0] reg_wdata_in,
  input logic       reg_rvalid_out,
  // engine and pin
  input logic       proximity_evt_in,
  input logic       conv_start_out,
  input logic       pair_ns_en_out,
  input logic       pair_we_en_out,
  input logic       gesture_mode_out,
  input logic       int_pin_out,
  input logic       int_pin_oe_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // saturates so the first start after reset never looks early
  logic [7:0] gap_q;
  always @(posedge clk_sys_in) begin
    if (rst_in)
      gap_q <= 8'hff;
    else if (conv_start_out)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end
  sequence s_dims_wr(logic [1:0] code);
    reg_wr_in && reg_addr_in == 8'haa && reg_wdata_in[1:0] == code;
  endsequence
  sequence s_run_wr;
    reg_wr_in && reg_addr_in == 8'hab && reg_wdata_in[0];
  endsequence
  property p_dims_both;
    (s_dims_wr(2'h0) or s_dims_wr(2'h3)) |-> ##2 (pair_ns_en_out && pair_we_en_out);
  endproperty
  a_dims_both: assert property (p_dims_both) else $error("pairs not both on");
  property p_dims_ns;
    s_dims_wr(2'h1) |-> ##2 (pair_ns_en_out && !pair_we_en_out);
  endproperty
  a_dims_ns: assert property (p_dims_ns) else $error("ns pair not alone");
  property p_dims_we;
    s_dims_wr(2'h2) |-> ##2 (!pair_ns_en_out && pair_we_en_out);
  endproperty
  a_dims_we: assert property (p_dims_we) else $error("we pair not alone");
  property p_pace_both;
    conv_start_out && pair_ns_en_out && pair_we_en_out |-> gap_q >= 8'd99;
  endproperty
  a_pace_both: assert property (p_pace_both) else $error("start too early");
  property p_pace_one;
    conv_start_out |-> gap_q >= 8'd49;
  endproperty
  a_pace_one: assert property (p_pace_one) else $error("start too early");
  property p_run;
    s_run_wr |-> ##2 gesture_mode_out;
  endproperty
  a_run: assert property (p_run) else $error("run not entered");
  property p_start_mode;
    conv_start_out |-> gesture_mode_out || $past(gesture_mode_out);
  endproperty
  a_start_mode: assert property (p_start_mode) else $error("start while idle");
  property p_rvalid;
    1'b1 |=> reg_rvalid_out == $past(reg_rd_in);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer misplaced");
  property p_evt_irq;
    proximity_evt_in |-> ##2 int_pin_oe_out;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("pin not asserted");
  property p_force;
    (reg_wr_in || reg_rd_in) && reg_addr_in == 8'he4 |-> ##2 int_pin_oe_out;
  endproperty
  a_force: assert property (p_force) else $error("force ignored");
  property p_od;
    !int_pin_out;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
endmodule // gcs_regs_checker

// ---- dv/test_gesture_control_status_regs.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_gesture_control_status_regs;
  typedef struct {logic [7:0] wd; logic raw; logic [7:0] rb; logic ns; logic we;} gcs_row_t;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, q, e;
  logic        reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic        conv_done_in = 1'b0;
  logic [31:0] conv_data_in = 32'h0000_0000;
  logic        conv_start_out, pair_ns_en_out, pair_we_en_out, gesture_mode_out, int_pin_out, int_pin_oe_out;
  logic [2:0]  evt = 3'h0;
  logic [2:0]  busy = 3'h0;
  logic [7:0]  cnt = 8'h00;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          k, j;
  gcs_row_t    rows[5] = '{'{8'h01, 0, 8'h01, 1, 0}, '{8'h02, 0, 8'h02, 0, 1}, '{8'h03, 0, 8'h03, 1, 1},
                           '{8'hfd, 1, 8'h01, 1, 0}, '{8'h00, 0, 8'h00, 1, 1}};
  logic [7:0]  ra[10] = '{8'haa, 8'hab, 8'hae, 8'haf, 8'h00, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'hae};
  logic [7:0]  ca[3] = '{8'he3, 8'he5, 8'he6};
  always #10 clk_sys_in = ~clk_sys_in;
  gcs_regs i_gcs_regs (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .fifo_threshold_in(8'h01), .entry_threshold_in(1'b0),
    .exit_threshold_in(1'b0), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .conv_start_out(conv_start_out), .pair_ns_en_out(pair_ns_en_out), .pair_we_en_out(pair_we_en_out),
    .gesture_mode_out(gesture_mode_out), .pattern_burst_evt_in(evt[0]), .proximity_evt_in(evt[1]),
    .light_evt_in(evt[2]), .int_pin_out(int_pin_out), .int_pin_oe_out(int_pin_oe_out));
  gcs_host_model i_gcs_host_model (.clk_sys_in(clk_sys_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in));
  // converter stand-in: answers five cycles after each start, data toggles outside the strobe
  always @(posedge clk_sys_in) begin
    conv_done_in <= 1'b0;
    conv_data_in <= ~conv_data_in;
    if (conv_start_out)
      busy <= 3'd5;
    else if (busy != 3'd0) begin
      busy <= busy - 3'd1;
      if (busy == 3'd1) begin
        conv_done_in <= 1'b1;
        conv_data_in <= {8'h10 + cnt, 8'h20 + cnt, 8'h30 + cnt, 8'h40 + cnt};
        cnt <= cnt + 8'h01;
      end
    end
  end
  task automatic rd(input logic [7:0] a);
    i_gcs_host_model.acc(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_gcs_host_model.acc(1'b1, a, d, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys_in);
    evt[i] <= 1'b1;
    @(posedge clk_sys_in);
    evt <= 3'h0;
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (rows[r]) begin
      i_gcs_host_model.raw = rows[r].raw;
      wr(8'haa, rows[r].wd);
      rd(8'haa);
      `CHK("dims", rows[r].rb, q)
      `CHK("pairs", {rows[r].ns, rows[r].we}, {pair_ns_en_out, pair_we_en_out})
    end
    i_gcs_host_model.raw = 1'b0;
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    `CHK("mode_rst", 1'b0, gesture_mode_out)
    foreach (ra[r]) begin
      rd(ra[r]);
      `CHK("rst_read", 8'h00, q)
    end
    for (k = 0; k < 3; k++) begin
      pulse(k);
      wt(3);
      `CHK("irq_set", 1'b1, int_pin_oe_out)
      if (k == 1) wr(ca[k], 8'hff); else rd(ca[k]);
      wt(3);
      `CHK("irq_clr", 1'b0, int_pin_oe_out)
    end
    wr(8'he4, 8'h00);
    pulse(0);
    pulse(2);
    rd(8'he5);
    wt(3);
    `CHK("irq_keep", 1'b1, int_pin_oe_out)
    rd(8'he7);
    wt(3);
    `CHK("irq_all", 1'b0, int_pin_oe_out)
    wr(8'haa, 8'h02);
    wr(8'hab, 8'h03);
    wt(1);
    `CHK("mode_run", 1'b1, gesture_mode_out)
    rd(8'hab);
    `CHK("ctrl", 8'h03, q)
    for (k = 0; k < 200 && q !== 8'd32; k++) begin
      wt(40);
      rd(8'hae);
    end
    wt(250);
    rd(8'he7);
    wt(3);
    `CHK("gest_irq", 1'b1, int_pin_oe_out)
    wr(8'hab, 8'h02);
    for (k = 0; k < 300 && gesture_mode_out; k++) wt(1);
    `CHK("mode_exit", 1'b0, gesture_mode_out)
    rd(8'hae);
    `CHK("level_full", 8'd32, q)
    rd(8'haf);
    `CHK("flags_full", 8'h03, q)
    wr(8'hab, 8'h00);
    wt(3);
    `CHK("gest_mask", 1'b0, int_pin_oe_out)
    for (k = 0; k < 32; k++) begin
      for (j = 0; j < 4; j++) begin
        rd(8'hfc + j[7:0]);
        e = (j < 2) ? 8'h00 : ((j == 2) ? 8'h30 + k[7:0] : 8'h40 + k[7:0]);
        `CHK("fifo_byte", e, q)
      end
      rd(8'hae);
      `CHK("level_pop", 8'd31 - k[7:0], q)
    end
    rd(8'haf);
    `CHK("flags_empty", 8'h00, q)
    rd(8'hfc);
    `CHK("fifo_empty", 8'h00, q)
    stop_test;
  end
endmodule // test_gesture_control_status_regs
bind gcs_regs gcs_regs_checker i_gcs_regs_checker (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_wdata_in, .reg_rvalid_out, .proximity_evt_in, .conv_start_out, .pair_ns_en_out,
  .pair_we_en_out, .gesture_mode_out, .int_pin_out, .int_pin_oe_out);

// ---- hdl/gcs_fifo.v ----
`timescale 1ns/1ps
`include "gcs_regs.vh"

module gcs_fifo (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // write side
  input  wire        push_in,
  input  wire [31:0] push_data_in,
  // read side
  input  wire        pop_in,
  output wire [31:0] head_out,
  output wire [7:0]  level_out,
  // overflow
  input  wire        ovf_clr_in,
  output wire        ovf_out
);
  reg [31:0]               mem_q [0:`GCS_FIFO_DEPTH-1];
  reg [`GCS_FIFO_AW-1:0]   wr_ptr_q;
  reg [`GCS_FIFO_AW-1:0]   rd_ptr_q;
  reg [7:0]                level_q;
  reg                      ovf_q;
  wire                     full;
  wire                     pop_ok;
  wire                     push_ok;

  assign full     = (level_q == 8'd`GCS_FIFO_DEPTH);
  assign pop_ok   = pop_in & (level_q != 8'h00);
  // a full fifo keeps its datasets; the new one is simply lost
  assign push_ok  = push_in & ~full;
  assign head_out = mem_q[rd_ptr_q];
  assign level_out = level_q;
  assign ovf_out  = ovf_q;

  always @(posedge clk_sys_in) begin
    if (push_ok) begin
      mem_q[wr_ptr_q] <= push_data_in;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_q <= {`GCS_FIFO_AW{1'b0}};
      rd_ptr_q <= {`GCS_FIFO_AW{1'b0}};
      level_q  <= 8'h00;
      ovf_q    <= 1'b0;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push_ok & ~pop_ok) begin
        level_q <= level_q + 8'h01;
      end else if (pop_ok & ~push_ok) begin
        level_q <= level_q - 8'h01;
      end
      // set wins over a clear in the same cycle
      if (push_in & full) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr_in) begin
        ovf_q <= 1'b0;
      end
    end
  end
endmodule // gcs_fifo

// ---- hdl/gcs_irq.v ----
`timescale 1ns/1ps

module gcs_irq (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // sources: pattern burst, proximity, light
  input  wire [2:0] src_evt_in,
  input  wire [2:0] src_clr_in,
  input  wire       clr_all_in,
  input  wire       force_in,
  // gesture source and its gate
  input  wire       gest_flag_in,
  input  wire       gest_en_in,
  // results
  output wire [2:0] src_flag_out,
  output reg        irq_out
);
  reg [2:0] flag_q;
  reg       force_q;
  genvar    gi;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_src
      always @(posedge clk_sys_in) begin
        if (rst_in) begin
          flag_q[gi] <= 1'b0;
        end else if (src_evt_in[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (src_clr_in[gi] | clr_all_in) begin
          flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      force_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (force_in) begin
        force_q <= 1'b1;
      end else if (clr_all_in) begin
        force_q <= 1'b0;
      end
      // gesture source passes only while enabled
      irq_out <= (|flag_q) | force_q | (gest_flag_in & gest_en_in);
    end
  end

  assign src_flag_out = flag_q;
endmodule // gcs_irq

// ---- hdl/gcs_regs.v ----
// Contract
// - codes 00/11: both pairs active, all valid
// - code 01: north-south only, west-east invalid
// - code 10: west-east only, north-south invalid
// - single pair collects at double rate
// - interrupt enable bit unmasks gesture interrupts
// - state bit reads 1 while gesture runs
// - writing 1 enters gesture immediately
// - writing 0 exits after current conversion
// - level counts complete datasets held
// - full dataset read decrements level
// - overflow bit set when data discarded
// - valid set when level exceeds threshold
// - valid cleared when idle and empty
// - late dataset keeps gesture interrupt set
// - read or write clears interrupt source
// - force register access asserts interrupt pin
// - separate clears for burst, proximity, light
// - combined clear spares gesture interrupt
// - full fifo drops new datasets
// - empty fifo reads return zero
`timescale 1ns/1ps
`include "gcs_regs.vh"

module gcs_regs (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // register port behind the serial slave
  input  wire [7:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  output reg         reg_rvalid_out,
  // gesture engine
  input  wire [7:0]  fifo_threshold_in,
  input  wire        entry_threshold_in,
  input  wire        exit_threshold_in,
  input  wire        conv_done_in,
  input  wire [31:0] conv_data_in,
  output reg         conv_start_out,
  output reg         pair_ns_en_out,
  output reg         pair_we_en_out,
  output reg         gesture_mode_out,
  // other interrupt sources
  input  wire        pattern_burst_evt_in,
  input  wire        proximity_evt_in,
  input  wire        light_evt_in,
  // open-drain interrupt pin
  output reg         int_pin_out,
  output wire        int_pin_oe_out
);

  function is_fifo_addr;
    input [7:0] addr;
    begin
      is_fifo_addr = (addr >= `GCS_ADDR_FIFO_N) && (addr <= `GCS_ADDR_FIFO_E);
    end
  endfunction

  function is_addr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       rd;
    input       wr;
    begin
      is_addr_hit = (rd | wr) && (addr == target);
    end
  endfunction

  localparam integer CONV_CYCLES_I = `GCS_CONV_CYCLES;
  localparam [7:0]   CONV_FULL     = CONV_CYCLES_I[7:0];
  localparam [7:0] CONV_HALF = CONV_FULL >> 1;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN  = 2'h1;
  localparam [1:0] ST_EXIT = 2'h2;

  // control state
  reg [1:0]  dims_q;
  reg [1:0]  dims_d;
  reg        irq_en_q;
  reg        irq_en_d;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg        conv_busy_q;
  reg        conv_busy_d;
  reg [7:0]  pace_cnt_q;
  reg [7:0]  pace_cnt_d;
  reg        valid_q;
  reg        gest_flag_q;
  reg [31:0] push_data;
  reg [7:0]  rdata_d;
  reg        ovf_clr;

  wire        gest_on;
  wire        acc;
  wire        ctrl_wr;
  wire        enter_req;
  wire        leave_req;
  wire        single_pair;
  wire [7:0]  pace_limit;
  wire        conv_start;
  wire        push;
  wire        pop;
  wire [31:0] head;
  wire [7:0]  level;
  wire        ovf;
  wire        above_thr;
  wire [2:0]  src_clr;
  wire        clr_all;
  wire        force_acc;
  wire        irq;

  assign acc     = reg_rd_in | reg_wr_in;
  assign ctrl_wr = reg_wr_in && (reg_addr_in == `GCS_ADDR_CTRL);
  assign gest_on = (state_q != ST_IDLE);

  // a host write behaves exactly like the threshold events
  assign enter_req = entry_threshold_in |
                     (ctrl_wr & reg_wdata_in[`GCS_CTRL_STATE]);
  assign leave_req = exit_threshold_in |
                     (ctrl_wr & ~reg_wdata_in[`GCS_CTRL_STATE]);

  // only bits 1:0 are kept; reserved bits are expected as zero
  always @* begin
    dims_d   = dims_q;
    irq_en_d = irq_en_q;
    if (reg_wr_in && (reg_addr_in == `GCS_ADDR_DIMS)) begin
      dims_d = reg_wdata_in[1:0];
    end
    if (ctrl_wr) begin
      irq_en_d = reg_wdata_in[`GCS_CTRL_IRQ_EN];
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (enter_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (enter_req) begin
          state_d = ST_RUN;
        end else if (leave_req) begin
          // nothing in flight means nothing to wait for
          state_d = (conv_busy_q & ~conv_done_in) ? ST_EXIT : ST_IDLE;
        end
      end
      ST_EXIT: begin
        if (enter_req) begin
          state_d = ST_RUN;
        end else if (conv_done_in | ~conv_busy_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // one pair active halves the pacing interval
  assign single_pair = (dims_q == `GCS_DIMS_NS_ONLY) || (dims_q == `GCS_DIMS_WE_ONLY);
  assign pace_limit  = single_pair ? CONV_HALF : CONV_FULL;
  assign conv_start  = (state_q == ST_RUN) && ~conv_busy_q &&
                       (pace_cnt_q >= pace_limit - 8'h01);

  always @* begin
    pace_cnt_d  = pace_cnt_q;
    conv_busy_d = conv_busy_q;
    if (state_q != ST_RUN) begin
      pace_cnt_d = 8'h00;
    end else if (conv_start) begin
      pace_cnt_d = 8'h00;
    end else if (pace_cnt_q < pace_limit) begin
      pace_cnt_d = pace_cnt_q + 8'h01;
    end
    if (conv_start) begin
      conv_busy_d = 1'b1;
    end else if (conv_done_in) begin
      conv_busy_d = 1'b0;
    end
  end

  // bytes of a disabled pair are stored as zero and are not valid
  always @* begin
    push_data = conv_data_in;
    case (dims_q)
      `GCS_DIMS_NS_ONLY: begin
        push_data = {conv_data_in[31:16], 16'h0000};
      end
      `GCS_DIMS_WE_ONLY: begin
        push_data = {16'h0000, conv_data_in[15:0]};
      end
      default: begin
        push_data = conv_data_in;
      end
    endcase
  end

  assign push = conv_done_in & conv_busy_q & gest_on;
  // the east byte closes a dataset, both single and paged reads
  assign pop  = reg_rd_in && (reg_addr_in == `GCS_ADDR_FIFO_E);

  gcs_fifo u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .push_in      (push),
    .push_data_in (push_data),
    .pop_in       (pop),
    .head_out     (head),
    .level_out    (level),
    .ovf_clr_in   (ovf_clr),
    .ovf_out      (ovf)
  );

  assign above_thr = (level > fifo_threshold_in);

  always @* begin
    ovf_clr = (level == 8'h00) & ~gest_on;
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      dims_q      <= `GCS_DIMS_RST;
      irq_en_q    <= `GCS_IRQ_EN_RST;
      state_q     <= ST_IDLE;
      conv_busy_q <= 1'b0;
      pace_cnt_q  <= 8'h00;
      valid_q     <= 1'b0;
      gest_flag_q <= 1'b0;
    end else begin
      dims_q      <= dims_d;
      irq_en_q    <= irq_en_d;
      state_q     <= state_d;
      conv_busy_q <= conv_busy_d;
      pace_cnt_q  <= pace_cnt_d;
      if (above_thr) begin
        valid_q <= 1'b1;
      end else if (~gest_on && (level == 8'h00)) begin
        valid_q <= 1'b0;
      end
      // the flag drops only when the last held dataset leaves;
      // a dataset landing during the read keeps it up
      if (above_thr) begin
        gest_flag_q <= 1'b1;
      end else if (pop && ~push && (level == 8'h01)) begin
        gest_flag_q <= 1'b0;
      end
    end
  end

  // any access counts; the data written is never looked at
  assign src_clr[0] = is_addr_hit(reg_addr_in, `GCS_ADDR_PB_CLR, reg_rd_in, reg_wr_in);
  assign src_clr[1] = is_addr_hit(reg_addr_in, `GCS_ADDR_PROX_CLR, reg_rd_in, reg_wr_in);
  assign src_clr[2] = is_addr_hit(reg_addr_in, `GCS_ADDR_LIGHT_CLR, reg_rd_in, reg_wr_in);
  assign clr_all    = is_addr_hit(reg_addr_in, `GCS_ADDR_ALL_CLR, reg_rd_in, reg_wr_in);
  assign force_acc  = is_addr_hit(reg_addr_in, `GCS_ADDR_FORCE, reg_rd_in, reg_wr_in);

  gcs_irq u_irq (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .src_evt_in   ({light_evt_in, proximity_evt_in, pattern_burst_evt_in}),
    .src_clr_in   (src_clr),
    .clr_all_in   (clr_all),
    .force_in     (force_acc),
    .gest_flag_in (gest_flag_q),
    .gest_en_in   (irq_en_q),
    .src_flag_out (),
    .irq_out      (irq)
  );

  // pin pulls low while an interrupt is pending
  assign int_pin_oe_out = irq;

  always @* begin
    rdata_d = 8'h00;
    if (is_fifo_addr(reg_addr_in)) begin
      if (level == 8'h00) begin
        rdata_d = 8'h00;
      end else begin
        case (reg_addr_in[1:0])
          2'h0: rdata_d = head[31:24];
          2'h1: rdata_d = head[23:16];
          2'h2: rdata_d = head[15:8];
          default: rdata_d = head[7:0];
        endcase
      end
    end else begin
      case (reg_addr_in)
        `GCS_ADDR_DIMS: begin
          rdata_d = {6'h00, dims_q};
        end
        `GCS_ADDR_CTRL: begin
          rdata_d = {6'h00, irq_en_q, gest_on};
        end
        `GCS_ADDR_LEVEL: begin
          rdata_d = level;
        end
        `GCS_ADDR_FLAGS: begin
          rdata_d = {6'h00, ovf, valid_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out    <= 8'h00;
      reg_rvalid_out   <= 1'b0;
      conv_start_out   <= 1'b0;
      pair_ns_en_out   <= 1'b1;
      pair_we_en_out   <= 1'b1;
      gesture_mode_out <= 1'b0;
      int_pin_out      <= 1'b0;
    end else begin
      reg_rvalid_out   <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
      conv_start_out   <= conv_start;
      pair_ns_en_out   <= (dims_q != `GCS_DIMS_WE_ONLY);
      pair_we_en_out   <= (dims_q != `GCS_DIMS_NS_ONLY);
      gesture_mode_out <= gest_on;
      int_pin_out      <= 1'b0;
    end
  end

  // unused bit of acc kept for clarity of the access decode
  wire unused_acc;
  assign unused_acc = acc;
endmodule // gcs_regs

// ---- hdl/gcs_regs.vh ----
`ifndef GCS_REGS_VH
`define GCS_REGS_VH

// register offsets
`define GCS_ADDR_DIMS      8'haa
`define GCS_ADDR_CTRL      8'hab
`define GCS_ADDR_LEVEL     8'hae
`define GCS_ADDR_FLAGS     8'haf
`define GCS_ADDR_PB_CLR    8'he3
`define GCS_ADDR_FORCE     8'he4
`define GCS_ADDR_PROX_CLR  8'he5
`define GCS_ADDR_LIGHT_CLR 8'he6
`define GCS_ADDR_ALL_CLR   8'he7
`define GCS_ADDR_FIFO_N    8'hfc
`define GCS_ADDR_FIFO_E    8'hff

// field positions
`define GCS_CTRL_IRQ_EN    1
`define GCS_CTRL_STATE     0
`define GCS_FLAGS_OVF      1
`define GCS_FLAGS_VALID    0

// dimension select codes
`define GCS_DIMS_BOTH_A    2'h0
`define GCS_DIMS_NS_ONLY   2'h1
`define GCS_DIMS_WE_ONLY   2'h2
`define GCS_DIMS_BOTH_B    2'h3

// reset values
`define GCS_DIMS_RST       2'h0
`define GCS_IRQ_EN_RST     1'b0
`define GCS_STATE_RST      1'b0

// fifo shape: 32 datasets of four bytes
`define GCS_FIFO_DEPTH     32
`define GCS_FIFO_AW        5

// conversion pacing with both pairs active
`define GCS_CLK_PERIOD_NS  20
`define GCS_CONV_PERIOD_NS 2000
`define GCS_CONV_CYCLES    (`GCS_CONV_PERIOD_NS / `GCS_CLK_PERIOD_NS)

`endif
